// *** design/cef_pkg.sv ***
package cef_pkg;

	// Register byte addresses on the serial configuration port
	localparam logic [7:0] CEF_FLAGS_ADDR   = 8'h10;
	localparam logic [7:0] CEF_MASKS_ADDR   = 8'h11;
	localparam logic [7:0] CEF_STATUS_ADDR  = 8'h12;
	localparam logic [7:0] CEF_DETAILS_ADDR = 8'h13;

	// Bit positions shared by flags, masks and live status
	localparam int unsigned BIT_INPUT_ADAPT  = 7;
	localparam int unsigned BIT_INPUT_VALID  = 6;
	localparam int unsigned BIT_INPUT_LIMIT  = 5;
	localparam int unsigned BIT_CHARGER      = 4;
	localparam int unsigned BIT_BATTERY      = 3;
	localparam int unsigned BIT_SPARE        = 2;
	localparam int unsigned BIT_CELL_DISC    = 1;
	localparam int unsigned BIT_BYPASS       = 0;

	// Detail register field positions
	localparam int unsigned DTL_INPUT_LSB    = 5;
	localparam int unsigned DTL_SENSE_LSB    = 1;

	// Reset values and the event bit mask
	localparam logic [7:0] FLAGS_RST         = 8'h00;
	localparam logic [7:0] MASKS_RST         = 8'hFF;
	localparam logic [7:0] STATUS_RST        = 8'hBB;
	localparam logic [7:0] DETAILS_RST       = 8'h00;
	localparam logic [7:0] EVENT_BITS        = 8'hFB;

	// Detail codes
	localparam logic [1:0] INPUT_VALID_CODE  = 2'h3;
	localparam logic [2:0] BAT_GOOD_CODE_A   = 3'h3;
	localparam logic [2:0] BAT_GOOD_CODE_B   = 3'h4;
	localparam logic [2:0] BAT_GOOD_CODE_C   = 3'h7;
	localparam logic [3:0] BYPASS_OK_CODE    = 4'h0;

	// Input current limit qualification time
	localparam longint unsigned CLK_HZ        = 20_000_000;
	localparam longint unsigned LIMIT_QUAL_MS = 30;
	localparam int unsigned LIMIT_QUAL_CYC    =
		int'((LIMIT_QUAL_MS * CLK_HZ + 999) / 1000);
	localparam int unsigned LIMIT_CNT_W       = 20;

endpackage : cef_pkg

// *** design/cef_limit_if.sv ***
// Carries the at-limit level to the qualifier and its verdict back
interface cef_limit_if;
	logic at_limit;
	logic limit_ok;

	modport src  (output at_limit, input  limit_ok);
	modport qual (input  at_limit, output limit_ok);
endinterface : cef_limit_if

// *** design/cef_limit_qual.sv ***
// Drops limit_ok only after a continuous at-limit run of QUAL_CYCLES
module cef_limit_qual #(
	parameter int unsigned QUAL_CYCLES = cef_pkg::LIMIT_QUAL_CYC
) (
	input  wire logic        mclk_i,
	input  wire logic        rstn_i,
	cef_limit_if.qual        lim
);

	localparam logic [cef_pkg::LIMIT_CNT_W-1:0] LAST =
		cef_pkg::LIMIT_CNT_W'(QUAL_CYCLES - 1);

	logic [cef_pkg::LIMIT_CNT_W-1:0] cnt_r;
	logic                            ok_r;
	wire                             run_done = (cnt_r == LAST);

	// Any gap in the limit condition restarts the run
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			cnt_r <= '0;
			ok_r  <= 1'b1;
		end else if (!lim.at_limit) begin
			cnt_r <= '0;
			ok_r  <= 1'b1;
		end else if (run_done) begin
			ok_r  <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	assign lim.limit_ok = ok_r;

endmodule : cef_limit_qual

// *** design/cef_event_unit.sv ***
module cef_event_unit #(
	parameter int unsigned LIMIT_QUAL_CYCLES = cef_pkg::LIMIT_QUAL_CYC
) (
	input  wire logic       mclk_i,
	input  wire logic       rstn_i,
	// Register access from the serial configuration port
	input  wire logic [7:0] reg_addr_i,
	input  wire logic       reg_rd_i,
	input  wire logic       reg_wr_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	output logic            reg_rvalid_o,
	// Charger core conditions, same clock
	input  wire logic       adapt_active_i,
	input  wire logic [1:0] input_detail_code_i,
	input  wire logic       input_at_limit_i,
	input  wire logic       charge_suspended_i,
	input  wire logic [2:0] battery_detail_code_i,
	input  wire logic [3:0] bypass_detail_code_i,
	input  wire logic       sense_pos_open_i,
	input  wire logic       sense_neg_open_i,
	input  wire logic [7:0] junction_temp_i,
	input  wire logic [7:0] thermal_threshold_setting_i,
	// Disconnect pin, asynchronous
	input  wire logic       cell_disconnect_input_i,
	// Outputs
	output logic            thermal_regulation_flag_o,
	output logic            irq_o
);

	// Returns true when a strobe hits a given address
	function automatic logic addr_hit(input logic strobe, input logic [7:0] addr,
		input logic [7:0] target);
		addr_hit = strobe && (addr == target);
	endfunction : addr_hit

	// Registers
	logic [7:0] flags_r;
	logic [7:0] flags_nxt;
	logic [7:0] masks_r;
	logic [7:0] masks_nxt;
	logic [7:0] status_r;
	logic [7:0] status_nxt;
	logic [7:0] details_r;
	logic [7:0] details_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic       rvalid_r;
	logic       thermal_flag_r;
	logic       thermal_flag_nxt;
	logic       irq_r;
	logic       irq_nxt;
	logic       disc_meta_r;
	logic       disc_sync_r;

	cef_limit_if lim_if ();

	// Disconnect pin synchroniser
	// Only the second stage is read; the first may still be settling
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			disc_meta_r <= 1'b0;
			disc_sync_r <= 1'b0;
		end else begin
			disc_meta_r <= cell_disconnect_input_i;
			disc_sync_r <= disc_meta_r;
		end
	end

	// Input current limit qualification
	assign lim_if.at_limit = input_at_limit_i;

	cef_limit_qual #(
		.QUAL_CYCLES (LIMIT_QUAL_CYCLES)
	) u_limit_qual (
		.mclk_i (mclk_i),
		.rstn_i (rstn_i),
		.lim    (lim_if.qual)
	);

	// Thermal regulation compare
	assign thermal_flag_nxt = (junction_temp_i > thermal_threshold_setting_i);

	// Individual live status terms
	wire adapt_ok   = ~adapt_active_i;
	wire valid_ok   = (input_detail_code_i == cef_pkg::INPUT_VALID_CODE);
	wire limit_ok   = lim_if.limit_ok;
	wire charger_ok = ~(charge_suspended_i | thermal_flag_nxt);
	wire bat_good   = (battery_detail_code_i == cef_pkg::BAT_GOOD_CODE_A)
		|| (battery_detail_code_i == cef_pkg::BAT_GOOD_CODE_B)
		|| (battery_detail_code_i == cef_pkg::BAT_GOOD_CODE_C);
	wire battery_ok = bat_good & ~charge_suspended_i;
	wire disc_ok    = ~disc_sync_r;
	wire bypass_ok  = (bypass_detail_code_i == cef_pkg::BYPASS_OK_CODE);

	// Live status byte in flag bit order
	always_comb begin
		status_nxt                           = '0;
		status_nxt[cef_pkg::BIT_INPUT_ADAPT] = adapt_ok;
		status_nxt[cef_pkg::BIT_INPUT_VALID] = valid_ok;
		status_nxt[cef_pkg::BIT_INPUT_LIMIT] = limit_ok;
		status_nxt[cef_pkg::BIT_CHARGER]     = charger_ok;
		status_nxt[cef_pkg::BIT_BATTERY]     = battery_ok;
		status_nxt[cef_pkg::BIT_CELL_DISC]   = disc_ok;
		status_nxt[cef_pkg::BIT_BYPASS]      = bypass_ok;
	end

	// Detail byte: input code and remote sense line state
	always_comb begin
		details_nxt = cef_pkg::DETAILS_RST;
		details_nxt[cef_pkg::DTL_INPUT_LSB +: 2] = input_detail_code_i;
		details_nxt[cef_pkg::DTL_SENSE_LSB +: 2] =
			{sense_neg_open_i, sense_pos_open_i};
	end

	// Access decode
	wire rd_flags   = addr_hit(reg_rd_i, reg_addr_i, cef_pkg::CEF_FLAGS_ADDR);
	wire rd_masks   = addr_hit(reg_rd_i, reg_addr_i, cef_pkg::CEF_MASKS_ADDR);
	wire rd_status  = addr_hit(reg_rd_i, reg_addr_i, cef_pkg::CEF_STATUS_ADDR);
	wire rd_details = addr_hit(reg_rd_i, reg_addr_i, cef_pkg::CEF_DETAILS_ADDR);
	wire wr_masks   = addr_hit(reg_wr_i, reg_addr_i, cef_pkg::CEF_MASKS_ADDR);

	// Change detect against the previous status; set wins over read clear
	// A change landing in the read cycle stays pending for the next read
	wire [7:0] changed = (status_nxt ^ status_r) & cef_pkg::EVENT_BITS;
	assign flags_nxt = (rd_flags ? cef_pkg::FLAGS_RST : flags_r) | changed;

	// Mask write, all eight bits stored
	assign masks_nxt = wr_masks ? reg_wdata_i : masks_r;

	// Combined request from unmasked flags
	assign irq_nxt = |(flags_nxt & ~masks_nxt);

	// Read data mux; unmapped addresses read zero
	assign rdata_nxt = rd_flags   ? flags_r   :
	                   rd_masks   ? masks_r   :
	                   rd_status  ? status_r  :
	                   rd_details ? details_r : 8'h00;

	// Live status capture, the reference for the next change detect
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			status_r <= cef_pkg::STATUS_RST;
		end else begin
			status_r <= status_nxt;
		end
	end

	// Detail byte capture
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			details_r <= cef_pkg::DETAILS_RST;
		end else begin
			details_r <= details_nxt;
		end
	end

	// Thermal flag, registered so the pin comes from a flop
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			thermal_flag_r <= 1'b0;
		end else begin
			thermal_flag_r <= thermal_flag_nxt;
		end
	end

	// Sticky event flags
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			flags_r <= cef_pkg::FLAGS_RST;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// Mask register, fully masked out of reset
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			masks_r <= cef_pkg::MASKS_RST;
		end else begin
			masks_r <= masks_nxt;
		end
	end

	// Read data, valid in the cycle of the read answer
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// Read answer strobe, one cycle after the read strobe
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= reg_rd_i;
		end
	end

	// Combined interrupt request level
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	assign reg_rdata_o               = rdata_r;
	assign reg_rvalid_o              = rvalid_r;
	assign thermal_regulation_flag_o = thermal_flag_r;
	assign irq_o                     = irq_r;

endmodule : cef_event_unit

// *** verification/cef_event_unit_properties.sv ***
// Watches the event unit's register port and status pins
module cef_event_unit_chk (
	input wire logic       mclk_i,
	input wire logic       rstn_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic       reg_rd_i,
	input wire logic       reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       reg_rvalid_o,
	input wire logic       adapt_active_i,
	input wire logic [1:0] input_detail_code_i,
	input wire logic       charge_suspended_i,
	input wire logic [2:0] battery_detail_code_i,
	input wire logic [3:0] bypass_detail_code_i,
	input wire logic       sense_pos_open_i,
	input wire logic       sense_neg_open_i,
	input wire logic [7:0] junction_temp_i,
	input wire logic [7:0] thermal_threshold_setting_i,
	input wire logic       cell_disconnect_input_i,
	input wire logic       thermal_regulation_flag_o,
	input wire logic       irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	// Expected status bits that follow same-clock inputs directly
	logic [7:0] exp_st;
	logic       hot;
	assign hot = junction_temp_i > thermal_threshold_setting_i;
	assign exp_st = {!adapt_active_i, input_detail_code_i == 2'h3, 1'h0, !(charge_suspended_i || hot),
		(battery_detail_code_i inside {3'h3, 3'h4, 3'h7}) && !charge_suspended_i, 2'h0,
		bypass_detail_code_i == 4'h0};
	sequence s_rd(logic [7:0] a);
		reg_rd_i && reg_addr_i == a;
	endsequence
	sequence s_wm;
		reg_wr_i && reg_addr_i == 8'h11;
	endsequence
	property p_rv; reg_rd_i |=> reg_rvalid_o; endproperty
	property p_unm; s_rd(8'h20) |=> reg_rdata_o == 8'h00; endproperty
	property p_st; s_rd(8'h12) ##0 $stable(exp_st) && $past(rstn_i)
		|=> (reg_rdata_o & 8'hDD) == $past(exp_st); endproperty
	property p_dtl; s_rd(8'h13) ##0 $stable({input_detail_code_i, sense_neg_open_i,
		sense_pos_open_i}) && $past(rstn_i) |=> reg_rdata_o == {1'h0, $past(input_detail_code_i),
		2'h0, $past(sense_neg_open_i), $past(sense_pos_open_i), 1'h0}; endproperty
	property p_wm; s_wm ##1 !reg_wr_i ##1 s_rd(8'h11) |=> reg_rdata_o == $past(reg_wdata_i, 3);
	endproperty
	property p_im; s_wm ##0 reg_wdata_i == 8'hFF |=> !irq_o; endproperty
	property p_rst; $rose(rstn_i) |-> !irq_o ##1 !irq_o; endproperty
	property p_tr; hot |=> thermal_regulation_flag_o; endproperty
	property p_dsc; cell_disconnect_input_i [*4] ##0 s_rd(8'h12) |=> !reg_rdata_o[1]; endproperty
	a_rv: assert property (p_rv) else $error("no read answer");
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	a_st: assert property (p_st) else $error("status bits wrong");
	a_dtl: assert property (p_dtl) else $error("detail bits wrong");
	a_wm: assert property (p_wm) else $error("mask readback wrong");
	a_im: assert property (p_im) else $error("masked request seen");
	a_rst: assert property (p_rst) else $error("request after reset");
	a_tr: assert property (p_tr) else $error("thermal flag low");
	a_dsc: assert property (p_dsc) else $error("disconnect status wrong");
endmodule : cef_event_unit_chk

bind cef_event_unit cef_event_unit_chk cef_event_unit_chk_inst (.*);

// *** verification/tb_top.sv ***
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk_i = 1'h0, rstn_i = 1'h0, reg_rd_i = 1'h0, reg_wr_i = 1'h0;
	logic        adapt_active_i = 1'h0, input_at_limit_i = 1'h0, charge_suspended_i = 1'h0;
	logic        sense_pos_open_i = 1'h0, sense_neg_open_i = 1'h0, cell_disconnect_input_i = 1'h0;
	logic        reg_rvalid_o, thermal_regulation_flag_o, irq_o;
	logic [1:0]  input_detail_code_i = 2'h0;
	logic [2:0]  battery_detail_code_i = 3'h0;
	logic [3:0]  bypass_detail_code_i = 4'h0;
	logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, junction_temp_i = 8'h00;
	logic [7:0]  thermal_threshold_setting_i = 8'h00, reg_rdata_o, d, m, prev, st;
	logic [31:0] r = 32'hD172;
	int          n_errors = 0, cmp_count = 0, cyc = 0;

	always #25 mclk_i = ~mclk_i;
	cef_event_unit #(.LIMIT_QUAL_CYCLES(16)) cef_event_unit_inst (.*);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// Live status the unit should report for the present inputs
	function automatic logic [7:0] exp_st();
		return {!adapt_active_i, input_detail_code_i == 2'h3, !input_at_limit_i,
			!(charge_suspended_i || junction_temp_i > thermal_threshold_setting_i),
			(battery_detail_code_i inside {3'h3, 3'h4, 3'h7}) && !charge_suspended_i, 1'h0,
			!cell_disconnect_input_i, bypass_detail_code_i == 4'h0};
	endfunction : exp_st
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a);
		@(negedge mclk_i);
		reg_rd_i = 1'h1;
		reg_addr_i = a;
		@(negedge mclk_i);
		reg_rd_i = 1'h0;
		chk(reg_rvalid_o, 8'h01);
		d = reg_rdata_o;
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge mclk_i);
		reg_wr_i = 1'h1;
		reg_addr_i = a;
		reg_wdata_i = v;
		@(negedge mclk_i);
		reg_wr_i = 1'h0;
	endtask : wr
	task automatic conclude();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : conclude

	// Hang guard
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			conclude();
		end
	end

	initial begin
		repeat (5) @(negedge mclk_i);
		rstn_i = 1'h1;
		rd(8'h11);
		chk(d, 8'hFF);
		rd(8'h20);
		chk(d, 8'h00);
		wr(8'h12, 8'h00);
		rd(8'h11);
		chk(d, 8'hFF);
		rd(8'h10);
		chk(d, (8'hBB ^ exp_st()) & 8'hFB);
		wr(8'h11, 8'hFF);
		prev = exp_st();
		for (int i = 0; i < 24; i++) begin
			r = lfsr(r);
			m = r[7:0];
			wr(8'h11, m);
			rd(8'h11);
			chk(d, m);
			r = lfsr(r);
			{adapt_active_i, input_detail_code_i, charge_suspended_i, battery_detail_code_i,
				bypass_detail_code_i, sense_pos_open_i, sense_neg_open_i,
				cell_disconnect_input_i} = r[13:0];
			junction_temp_i = r[21:14];
			thermal_threshold_setting_i = r[29:22];
			if (r[30]) bypass_detail_code_i = 4'h0;
			repeat (4) @(negedge mclk_i);
			st = exp_st();
			chk(thermal_regulation_flag_o, junction_temp_i > thermal_threshold_setting_i);
			chk(irq_o, |((prev ^ st) & 8'hFB & ~m));
			rd(8'h12);
			chk(d, st);
			rd(8'h13);
			chk(d, {1'h0, input_detail_code_i, 2'h0, sense_neg_open_i, sense_pos_open_i, 1'h0});
			rd(8'h10);
			chk(d, (prev ^ st) & 8'hFB);
			rd(8'h10);
			chk(d, 8'h00);
			chk(irq_o, 8'h00);
			prev = st;
		end
		// Qualified current limit, one continuous run read before and after its full length
		input_at_limit_i = 1'h1;
		repeat (8) @(negedge mclk_i);
		rd(8'h12);
		chk(d[5], 1'h1);
		repeat (12) @(negedge mclk_i);
		rd(8'h12);
		chk(d[5], 1'h0);
		rd(8'h10);
		chk(d, 8'h20);
		input_at_limit_i = 1'h0;
		repeat (3) @(negedge mclk_i);
		rd(8'h12);
		chk(d, exp_st());
		conclude();
	end
endmodule : tb_top
